// >>> rtl/cbc_cycle_break_control.sv
// Purpose: cycle control sequencer of a light curtain receiver
// Assumes: inputs synchronous to aclk; field_free high when field is clear
// Notes: registers over AXI4-Lite; one level interrupt output
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.

// Overview of operation
// - Any cycle mode forces the start interlock whatever its setting.
// - After reset in a cycle mode the interlock is engaged, outputs off.
// - The yellow indicator is lit while the interlock is engaged.
// - Only a press released within the start window, or clearing the interlock select in guard mode, frees the interlock.
// - Modes with 1 to 8 interventions share one sequence and a count.
// - After the last expected break, a free field starts the cycle.
// - The clear sensor ends a work cycle and returns to stop, outputs off.
// - A break in a work cycle drops outputs and demands a start press.
// - Breaks not complete within the time limit cause a lockout.
// - A break counts only if it lasts longer than the minimum duration.
// - Too many breaks in the stop phase lock out instead of starting.
// - A break on the return stroke also stops unless bypass is active.
// - Double-break mode starts only after the second valid break.
// - An active cycle reset clears the count and blocks counting.
module cbc_cycle_break_control
  import cbc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic field_free,
  input wire logic clear_sensor,
  input wire logic start_button,
  input wire logic return_stroke,
  input wire logic cycle_reset,
  output logic safety_switch_outputs,
  output logic interlock_led,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  cbc_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] break_tmr_ff, nxt_break_tmr;
  logic [CNT_W-1:0] limit_tmr_ff, nxt_limit_tmr;
  logic [CNT_W-1:0] press_tmr_ff, nxt_press_tmr;
  logic [3:0] count_ff, nxt_count;
  logic field_prev_ff, nxt_field_prev;
  logic in_break_ff, nxt_in_break;
  logic safety_switch_outputs_ff, nxt_safety_switch_outputs;
  logic led_ff, nxt_led;
  logic [IRQ_W-1:0] ev;

  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [IRQ_W-1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
  logic irq_ff, nxt_irq;
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, ar_ff, nxt_ar, rv_ff;
  logic nxt_rv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0] ws_ff, nxt_ws;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;

  logic [3:0] mode;
  logic cycle_mode, guard_sri, cr_active, brk_edge, brk_end, brk_valid;
  always_comb begin
    mode = ctrl_ff[CTRL_MODE_LSB +: CTRL_MODE_W];
    cycle_mode = (mode != 4'h0) && (mode <= 4'h8);
    guard_sri = ctrl_ff[CTRL_SRI_BIT];
    cr_active = (cycle_reset == ctrl_ff[CTRL_CRPOL_BIT]);
    brk_edge = field_prev_ff && !field_free;
    brk_end = in_break_ff && field_free;
    brk_valid = brk_end && (break_tmr_ff > CNT_W'(MIN_BREAK_CYC));
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_field_prev = field_free;
    nxt_in_break = in_break_ff;
    nxt_break_tmr = break_tmr_ff;
    nxt_limit_tmr = limit_tmr_ff;
    nxt_press_tmr = press_tmr_ff;
    ev = '0;
    if (brk_edge) begin
      nxt_in_break = 1'b1;
      nxt_break_tmr = '0;
    end else if (brk_end) begin
      nxt_in_break = 1'b0;
    end else if (in_break_ff && break_tmr_ff != '1) begin
      nxt_break_tmr = break_tmr_ff + 1'b1;
    end
    case (state_ff)
      CBC_LOCKED: begin
        nxt_count = '0;
        if (!cycle_mode && !guard_sri) begin
          nxt_state = CBC_GUARD;
        end else if (start_button && field_free) begin
          nxt_press_tmr = '0;
          nxt_state = CBC_START_PRESS;
        end
      end
      CBC_START_PRESS: begin
        if (!start_button) begin
          // released in time frees the interlock
          nxt_limit_tmr = '0;
          nxt_state = cycle_mode ? CBC_STOP : CBC_GUARD;
        end else if (press_tmr_ff >= CNT_W'(START_WIN_CYC)) begin
          nxt_state = CBC_LOCKED;  // held too long
        end else begin
          nxt_press_tmr = press_tmr_ff + 1'b1;
        end
      end
      CBC_STOP: begin
        if (!cycle_mode) begin
          nxt_state = guard_sri ? CBC_LOCKED : CBC_GUARD;
        end else if (cr_active) begin
          nxt_count = '0;
          nxt_limit_tmr = '0;
        end else if (brk_valid) begin
          if (count_ff + 4'h1 > mode) begin
            nxt_state = CBC_LOCKED;
            ev[IRQ_LOCKOUT] = 1'b1;
          end else begin
            nxt_count = count_ff + 4'h1;
          end
        end else if (limit_tmr_ff >= CNT_W'(CYCLE_LIMIT_CYC)) begin
          nxt_state = CBC_LOCKED;
          ev[IRQ_LOCKOUT] = 1'b1;
        end else begin
          nxt_limit_tmr = limit_tmr_ff + 1'b1;
          // field free after the last expected break starts
          if (count_ff == mode && field_free && !in_break_ff) begin
            nxt_state = CBC_WORK;
            ev[IRQ_CYC_START] = 1'b1;
          end
        end
      end
      CBC_WORK: begin
        if (!field_free && !(return_stroke && ctrl_ff[CTRL_BYP_BIT])) begin
          nxt_state = CBC_LOCKED;
          ev[IRQ_LOCKOUT] = 1'b1;
        end else if (clear_sensor) begin
          nxt_state = CBC_STOP;
          nxt_count = '0;
          nxt_limit_tmr = '0;
          ev[IRQ_CYC_END] = 1'b1;
        end
      end
      CBC_GUARD: begin
        // guard without interlock: outputs follow the field
        if (cycle_mode || guard_sri) begin
          nxt_state = CBC_LOCKED;
        end
      end
      default: nxt_state = CBC_LOCKED;
    endcase
    nxt_safety_switch_outputs = (nxt_state == CBC_WORK) ||
               (nxt_state == CBC_GUARD && field_free);
    nxt_led = (nxt_state == CBC_LOCKED) ||
              (nxt_state == CBC_START_PRESS);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= CBC_LOCKED;
      count_ff <= '0;
      field_prev_ff <= 1'b0;
      in_break_ff <= 1'b0;
      break_tmr_ff <= '0;
      limit_tmr_ff <= '0;
      press_tmr_ff <= '0;
      safety_switch_outputs_ff <= 1'b0;
      led_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      field_prev_ff <= nxt_field_prev;
      in_break_ff <= nxt_in_break;
      break_tmr_ff <= nxt_break_tmr;
      limit_tmr_ff <= nxt_limit_tmr;
      press_tmr_ff <= nxt_press_tmr;
      safety_switch_outputs_ff <= nxt_safety_switch_outputs;
      led_ff <= nxt_led;
    end
  end

  // axi4-lite slave: one access of each kind at a time
  logic wr_go, rd_go;
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_ar = ar_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_ien = ien_ff;
    nxt_ist = ist_ff;
    if (s_axi_awvalid && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff && !bv_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    wr_go = aw_ff && w_ff && !bv_ff;
    if (wr_go) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OKAY;
      case (awa_ff)
        OFF_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            if (ws_ff[i]) nxt_ctrl[i*8 +: 8] = wd_ff[i*8 +: 8];
          end
        end
        OFF_IRQ_EN: if (ws_ff[0]) nxt_ien = wd_ff[IRQ_W-1:0];
        OFF_IRQ_CLR: if (ws_ff[0]) nxt_ist = ist_ff & ~wd_ff[IRQ_W-1:0];
        OFF_STATUS, OFF_IRQ_STAT: nxt_br = RESP_OKAY;
        default: nxt_br = RESP_SLVERR;
      endcase
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    // new events win over a clear in the same cycle
    nxt_ist = nxt_ist | ev;
    nxt_irq = |(nxt_ist & nxt_ien);
    rd_go = s_axi_arvalid && !ar_ff && !rv_ff;
    nxt_ar = rd_go;
    if (rd_go) begin
      nxt_rr = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: nxt_rd = ctrl_ff;
        OFF_STATUS: nxt_rd = {20'h0_0000, count_ff, 1'b0, 3'(state_ff),
                              1'b0, led_ff, safety_switch_outputs_ff, cycle_mode};
        OFF_IRQ_STAT: nxt_rd = {29'h0, ist_ff};
        OFF_IRQ_EN: nxt_rd = {29'h0, ien_ff};
        OFF_IRQ_CLR: nxt_rd = 32'h0000_0000;
        default: begin
          nxt_rd = 32'h0000_0000;
          nxt_rr = RESP_SLVERR;
        end
      endcase
    end
    // rvalid only after the address handshake, never on its edge
    if (ar_ff) begin
      nxt_rv = 1'b1;
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= RESP_OKAY;
      ar_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= RESP_OKAY;
      ctrl_ff <= CTRL_RST;
      ien_ff <= '0;
      ist_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      ar_ff <= nxt_ar;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
      ctrl_ff <= nxt_ctrl;
      ien_ff <= nxt_ien;
      ist_ff <= nxt_ist;
      irq_ff <= nxt_irq;
    end
  end

  // awready/wready pulse on the same edge that captures the beat
  logic awr_ff, wr_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      awr_ff <= s_axi_awvalid && !aw_ff && !bv_ff && !awr_ff;
      wr_ff <= s_axi_wvalid && !w_ff && !bv_ff && !wr_ff;
    end
  end

  always_comb begin
    safety_switch_outputs = safety_switch_outputs_ff;
    interlock_led = led_ff;
    irq = irq_ff;
    s_axi_awready = awr_ff;
    s_axi_wready = wr_ff;
    s_axi_bvalid = bv_ff;
    s_axi_bresp = br_ff;
    s_axi_arready = ar_ff;
    s_axi_rvalid = rv_ff;
    s_axi_rdata = rd_ff;
    s_axi_rresp = rr_ff;
  end
endmodule // cbc_cycle_break_control

// >>> pkg/cbc_pkg.sv
// Purpose: constants and types for the cycle break control sequencer
// Assumes: 100 MHz aclk
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package cbc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // factory default times
  localparam int unsigned CYCLE_LIMIT_S = 30;
  localparam int unsigned MIN_BREAK_MS = 100;
  localparam int unsigned START_WIN_MS = 2000;
  localparam int unsigned CYCLE_LIMIT_CYC = CYCLE_LIMIT_S * CLK_HZ;
  localparam int unsigned MIN_BREAK_CYC = MIN_BREAK_MS * (CLK_HZ / 1000);
  localparam int unsigned START_WIN_CYC = START_WIN_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 32;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;   // 0 guard, 1..8 breaks
  localparam int CTRL_MODE_W = 4;
  localparam int CTRL_SRI_BIT = 4;    // interlock selected in guard mode
  localparam int CTRL_BYP_BIT = 5;    // bypass active
  localparam int CTRL_CRPOL_BIT = 6;  // cycle reset active level
  localparam logic [31:0] CTRL_RST = 32'h0000_0011;

  // irq bits
  localparam int IRQ_CYC_START = 0;
  localparam int IRQ_CYC_END = 1;
  localparam int IRQ_LOCKOUT = 2;
  localparam int IRQ_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    CBC_LOCKED, CBC_START_PRESS, CBC_STOP, CBC_WORK, CBC_GUARD
  } cbc_state_t;
endpackage

// >>> test/cbc_assertions.sv
// Purpose: port checks for cbc_cycle_break_control
// Assumes: one aclk domain, sync active-low reset
// Notes: bound into the top module
module cbc_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic field_free,
  input wire logic clear_sensor,
  input wire logic start_button,
  input wire logic return_stroke,
  input wire logic safety_switch_outputs,
  input wire logic interlock_led,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pressed_ff;
  logic nxt_pressed;
  // remembers any press since reset; release needs one
  always_comb nxt_pressed = pressed_ff | start_button;
  always_ff @(posedge aclk) begin
    if (!aresetn) pressed_ff <= 1'b0;
    else pressed_ff <= nxt_pressed;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_off;
    ##[1:2] !safety_switch_outputs;
  endsequence
  reset_state_a: assert property (
    $rose(aresetn) |-> interlock_led && !safety_switch_outputs)
    else $error("outputs wrong after reset");
  lock_off_a: assert property (
    interlock_led |-> !safety_switch_outputs)
    else $error("outputs on while interlock engaged");
  press_release_a: assert property (
    $fell(interlock_led) |-> pressed_ff && !$past(start_button))
    else $error("interlock freed without press and release");
  start_free_a: assert property (
    $rose(safety_switch_outputs) |-> $past(field_free))
    else $error("outputs on with field broken");
  break_stop_a: assert property (
    safety_switch_outputs && !field_free && !return_stroke |-> s_off)
    else $error("break in work cycle left outputs on");
  clear_stop_a: assert property (
    safety_switch_outputs && clear_sensor |-> s_off)
    else $error("clear sensor left outputs on");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // cbc_assertions

bind cbc_cycle_break_control cbc_assertions i_chk (
  .aclk(aclk), .aresetn(aresetn), .field_free(field_free),
  .clear_sensor(clear_sensor), .start_button(start_button),
  .return_stroke(return_stroke),
  .safety_switch_outputs(safety_switch_outputs),
  .interlock_led(interlock_led), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// >>> test/cbc_env.sv
// Purpose: operator, clear sensor and machine side model
// Assumes: changes land just after a rising aclk edge
// Notes: breaks stay far below the minimum duration to keep runs short
module cbc_env (
  input wire logic aclk,
  output logic field_free,
  output logic clear_sensor,
  output logic start_button,
  output logic return_stroke,
  output logic cycle_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    field_free = 1'b1;
    clear_sensor = 1'b0;
    start_button = 1'b0;
    return_stroke = 1'b0;
    cycle_reset = 1'b1;
  end
  task automatic press(input int n);
    @(posedge aclk);
    start_button <= 1'b1;
    repeat (n) @(posedge aclk);
    start_button <= 1'b0;
  endtask
  task automatic brk(input int n);
    @(posedge aclk);
    field_free <= 1'b0;
    repeat (n) @(posedge aclk);
    field_free <= 1'b1;
  endtask
endmodule // cbc_env

// >>> test/cbc_cycle_break_control_test.sv
// Purpose: self-checking bench for cbc_cycle_break_control
// Assumes: 100 MHz aclk, AXI4-Lite master in this module
// Notes: full-length timers cannot elapse in a short run
module cbc_cycle_break_control_test;
  import cbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn = 1'b0, ff, clr, sb, rs, cr, so, led, irq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
  logic arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  cbc_env i_env (.aclk(aclk), .field_free(ff), .clear_sensor(clr),
    .start_button(sb), .return_stroke(rs), .cycle_reset(cr));
  cbc_cycle_break_control i_dut (.aclk(aclk), .aresetn(aresetn),
    .field_free(ff), .clear_sensor(clr), .start_button(sb),
    .return_stroke(rs), .cycle_reset(cr), .safety_switch_outputs(so),
    .interlock_led(led), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a hung handshake would otherwise stall the run forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_reset();
    chk(so, 32'h0);
    chk(led, 32'h1);
    chk(irq, 32'h0);
    rd(OFF_CTRL);
    chk(d, CTRL_RST);
    rd(OFF_STATUS);
    chk(d, 32'h5);
  endtask
  task automatic t_sri_off();
    wr(OFF_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(led, 32'h1);
  endtask
  task automatic t_press_broken();
    fork
      i_env.brk(40);
      begin
        repeat (5) @(posedge aclk);
        i_env.press(5);
      end
    join
    repeat (3) @(posedge aclk);
    chk(led, 32'h1);
    rd(OFF_STATUS);
    chk(d, 32'h5);
  endtask
  task automatic t_start();
    i_env.press(4);
    repeat (3) @(posedge aclk);
    chk(led, 32'h0);
    chk(so, 32'h0);
    rd(OFF_STATUS);
    chk(d, 32'h21);
  endtask
  task automatic t_short_break();
    i_env.brk(50);
    repeat (3) @(posedge aclk);
    chk(so, 32'h0);
    rd(OFF_STATUS);
    chk(d, 32'h21);
  endtask
  task automatic t_regs();
    rd(8'h14);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h14, 32'h1);
    chk(r, RESP_SLVERR);
    wr(OFF_STATUS, 32'hff);
    chk(r, RESP_OKAY);
    rd(OFF_STATUS);
    chk(d, 32'h21);
    wr(OFF_IRQ_EN, 32'h7);
    rd(OFF_IRQ_EN);
    chk(d, 32'h7);
    wr(OFF_IRQ_CLR, 32'h7);
    rd(OFF_IRQ_STAT);
    chk(d, 32'h0);
    chk(irq, 32'h0);
  endtask
  task automatic t_guard();
    wr(OFF_CTRL, 32'h10);
    chk(r, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(led, 32'h1);
    rd(OFF_STATUS);
    chk(d, 32'h4);
    wr(OFF_CTRL, 32'h0);
    repeat (3) @(posedge aclk);
    chk(led, 32'h0);
    chk(so, 32'h1);
    rd(OFF_STATUS);
    chk(d, 32'h42);
    // guard mode outputs follow the field
    fork
      i_env.brk(10);
      begin
        repeat (5) @(posedge aclk);
        chk(so, 32'h0);
      end
    join
    repeat (3) @(posedge aclk);
    chk(so, 32'h1);
    wr(OFF_CTRL, 32'h11);
    repeat (3) @(posedge aclk);
    chk(led, 32'h1);
    chk(so, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_sri_off();
    t_press_broken();
    t_start();
    t_short_break();
    t_regs();
    t_guard();
    complete_run();
  end
endmodule // cbc_cycle_break_control_test
